// ===== sue_params.svh
// Constants for the synchronous serial engine
`ifndef SUE_PARAMS_SVH
`define SUE_PARAMS_SVH
`define SUE_SEL_DATA 1'b0
`define SUE_SEL_CTL 1'b1
`define SUE_MODE_FMT_HI 1
`define SUE_MODE_FMT_LO 0
`define SUE_MODE_LEN_HI 3
`define SUE_MODE_LEN_LO 2
`define SUE_MODE_PAR_EN 4
`define SUE_MODE_PAR_EVEN 5
`define SUE_MODE_EXT_SYNC 6
`define SUE_MODE_SINGLE 7
`define SUE_FMT_SYNC 2'h0
`define SUE_MIN_LEN 4'h5
`define SUE_CMD_TX_PERMIT 0
`define SUE_CMD_DTR 1
`define SUE_CMD_RX_PERMIT 2
`define SUE_CMD_FAULT_CLEAR 4
`define SUE_CMD_RTS 5
`define SUE_CMD_SOFT_REINIT 6
`define SUE_CMD_SEARCH_STATE 7
`define SUE_ST_SLOT_FREE 0
`define SUE_ST_RX_READY 1
`define SUE_ST_TX_IDLE 2
`define SUE_ST_PARITY 3
`define SUE_ST_OVERRUN 4
`define SUE_ST_FRAME 5
`define SUE_ST_SYNC_FOUND 6
`define SUE_ST_DSR 7
`define SUE_RST_BYTE 8'h00
`define SUE_PIN_RST 6'h3e
`define SUE_STATUS_DELAY 16
`endif

// ===== sue_pkg.sv
// Types shared by the synchronous serial engine
package sue_pkg;
  typedef enum logic [1:0] {
    CTL_MODE = 2'b00,
    CTL_SYNC1 = 2'b01,
    CTL_SYNC2 = 2'b10,
    CTL_CMD = 2'b11
  } sue_ctl_state_t;
  typedef enum logic [1:0] {
    RX_SEARCH_STATE = 2'b00,
    RX_HUNT2 = 2'b01,
    RX_IDLE = 2'b10,
    RX_DATA = 2'b11
  } sue_rx_state_t;
endpackage

// ===== sue_tx.sv
// Transmit shifter: one bit per falling bit-clock edge
`timescale 1ns/100ps
module sue_tx (
  input wire logic clock,
  input wire logic rst,
  input wire logic shiftNow,
  input wire logic loadValid,
  input wire logic [10:0] loadFrame,
  input wire logic [3:0] loadLen,
  output logic taking,
  output logic lastBit,
  output logic txd
);
  logic [10:0] shifter;
  logic [3:0] remain;

  // Next frame joins the stream with no gap
  assign taking = shiftNow && loadValid && (remain <= 4'h1);
  assign lastBit = (remain == 4'h1);

  always_ff @(posedge clock) begin
    if (rst) begin
      shifter <= 11'h000;
      remain <= 4'h0;
      txd <= 1'b1;
    end else if (taking) begin
      txd <= loadFrame[0];
      shifter <= loadFrame >> 1;
      remain <= loadLen;
    end else if (shiftNow && remain > 4'h1) begin
      txd <= shifter[0];
      shifter <= shifter >> 1;
      remain <= remain - 4'h1;
    end else if (shiftNow) begin
      txd <= 1'b1;
      remain <= 4'h0;
    end
  end
endmodule // sue_tx

// ===== sue_rx.sv
// Receiver: search_state, sync match and character assembly
`timescale 1ns/100ps
module sue_rx (
  input wire logic clock,
  input wire logic rst,
  input wire logic restart,
  input wire logic bitNow,
  input wire logic bitIn,
  input wire logic enable,
  input wire logic huntReq,
  input wire logic extSync,
  input wire logic extMode,
  input wire logic asyncMode,
  input wire logic dblSync,
  input wire logic [3:0] len,
  input wire logic parEn,
  input wire logic parEven,
  input wire logic [7:0] sync1,
  input wire logic [7:0] sync2,
  output logic charDone,
  output logic [7:0] rxData,
  output logic parityBad,
  output logic frameBad,
  output logic syncHit
);
  sue_pkg::sue_rx_state_t state;
  logic [7:0] win, nw, dataNow;
  logic [3:0] cnt, lastIdx;
  logic parBit, parNow;

  // Right shift leaves unused upper bits zero
  function automatic logic [7:0] align(input logic [7:0] w,
                                       input logic [3:0] n);
    align = w >> (4'h8 - n);
  endfunction

  assign lastIdx = len - 4'h1 + {3'h0, parEn} + {3'h0, asyncMode};

  always_comb begin
    nw = {bitIn, win[7:1]};
    dataNow = (cnt < len) ? align(nw, len) : align(win, len);
    parNow = (cnt == len) ? bitIn : parBit;
  end

  always_ff @(posedge clock) begin
    if (rst || restart) begin
      state <= sue_pkg::RX_SEARCH_STATE;
      win <= 8'h00;
      cnt <= 4'h0;
      parBit <= 1'b0;
      charDone <= 1'b0;
      rxData <= 8'h00;
      parityBad <= 1'b0;
      frameBad <= 1'b0;
      syncHit <= 1'b0;
    end else begin
      charDone <= 1'b0;
      syncHit <= 1'b0;
      if (huntReq && !extMode) begin
        state <= sue_pkg::RX_SEARCH_STATE;
      end else if (extSync && state == sue_pkg::RX_SEARCH_STATE) begin
        state <= sue_pkg::RX_DATA;
        cnt <= 4'h0;
      end else if (enable && bitNow) begin
        case (state)
          sue_pkg::RX_SEARCH_STATE: begin
            win <= nw;
            if (asyncMode) begin
              state <= sue_pkg::RX_IDLE;
            end else if (!extMode && align(nw, len) == align(sync1, len)) begin
              cnt <= 4'h0;
              state <= dblSync ? sue_pkg::RX_HUNT2 : sue_pkg::RX_DATA;
              syncHit <= !dblSync;
            end
          end
          sue_pkg::RX_HUNT2: begin
            win <= nw;
            cnt <= cnt + 4'h1;
            if (cnt == len - 4'h1) begin
              cnt <= 4'h0;
              // Sampled mid-bit of the second sync character
              syncHit <= align(nw, len) == align(sync2, len);
              state <= align(nw, len) == align(sync2, len) ?
                       sue_pkg::RX_DATA : sue_pkg::RX_SEARCH_STATE;
            end
          end
          sue_pkg::RX_IDLE: begin
            cnt <= 4'h0;
            if (!bitIn) begin
              state <= sue_pkg::RX_DATA;
            end
          end
          sue_pkg::RX_DATA: begin
            if (cnt < len) begin
              win <= nw;
            end
            if (cnt == len) begin
              parBit <= bitIn;
            end
            cnt <= cnt + 4'h1;
            if (cnt == lastIdx) begin
              cnt <= 4'h0;
              charDone <= 1'b1;
              rxData <= dataNow;
              parityBad <= parEn && (^dataNow ^ parNow ^ !parEven);
              frameBad <= asyncMode && !bitIn;
              if (asyncMode) begin
                state <= sue_pkg::RX_IDLE;
              end
            end
          end
          default: state <= sue_pkg::RX_SEARCH_STATE;
        endcase
      end
    end
  end
endmodule // sue_rx

// ===== sue_engine.sv
// Synchronous serial engine: host port, control words, status, link
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps
`include "sue_params.svh"
module sue_engine (
  input wire logic clock,
  input wire logic rst,
  input wire logic cdSel,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  input wire logic transmitBitClock,
  input wire logic receiveBitClock,
  input wire logic rxdPin,
  input wire logic ctsN,
  input wire logic dsrN,
  input wire logic syncFoundIn,
  output logic txd,
  output logic rtsN,
  output logic dtrN,
  output logic transmitSlotFree,
  output logic rxReadyPin,
  output logic transmitterIdleFlag,
  output logic syncFoundOut,
  output logic syncFoundOe
);
  localparam int NPIN = 6;
  localparam logic [NPIN-1:0] PIN_RST = `SUE_PIN_RST;

  sue_pkg::sue_ctl_state_t ctlState;
  logic [7:0] mode, sync1, sync2, command, txBuf, status, txChar, dataMasked;
  logic [NPIN-1:0] pinRaw, pinMeta, pinSync, pinLast;
  logic txFall, txRise, rxRise, ctsOk, extEdge;
  logic ctlWr, dataWr, stRd, dataRd, cmdWr, modeWr, softRst, faultClr;
  logic syncMode, asyncMode, extMode, dblSync, parEn, parEven;
  logic txPermit, rxPermit, operational, huntReq;
  logic [3:0] charLen, txLen;
  logic [10:0] txFrame;
  logic bufFull, txStarted, fillSel, loadValid, taking, lastBit, parBit;
  logic idleSet;
  logic rxCharDone, rxParityBad, rxFrameBad, syncHit;
  logic [7:0] rxData;
  logic rxReady, overrun, parityFault, frameFault, syncFound;

  function automatic logic isSync(input logic [7:0] m);
    isSync = m[`SUE_MODE_FMT_HI:`SUE_MODE_FMT_LO] == `SUE_FMT_SYNC;
  endfunction

  function automatic logic [7:0] lenMask(input logic [3:0] n);
    lenMask = 8'hff >> (4'h8 - n);
  endfunction

  // Link pins are asynchronous to the engine clock
  assign pinRaw = {transmitBitClock, receiveBitClock, rxdPin, ctsN, dsrN,
                   syncFoundIn};
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge clock) begin
        if (rst) begin
          pinMeta[g] <= PIN_RST[g];
          pinSync[g] <= PIN_RST[g];
          pinLast[g] <= PIN_RST[g];
        end else begin
          pinMeta[g] <= pinRaw[g];
          pinSync[g] <= pinMeta[g];
          pinLast[g] <= pinSync[g];
        end
      end
    end
  endgenerate

  assign txFall = pinLast[5] && !pinSync[5];
  assign txRise = !pinLast[5] && pinSync[5];
  assign rxRise = !pinLast[4] && pinSync[4];
  assign ctsOk = !pinSync[2];
  assign extEdge = pinSync[0] && !pinLast[0];

  // Host port decode
  assign ctlWr = wrStb && cdSel == `SUE_SEL_CTL;
  assign dataWr = wrStb && cdSel == `SUE_SEL_DATA;
  assign stRd = rdStb && cdSel == `SUE_SEL_CTL;
  assign dataRd = rdStb && cdSel == `SUE_SEL_DATA;
  assign modeWr = ctlWr && ctlState == sue_pkg::CTL_MODE;
  assign cmdWr = ctlWr && ctlState == sue_pkg::CTL_CMD;
  assign softRst = cmdWr && wrData[`SUE_CMD_SOFT_REINIT];
  assign faultClr = cmdWr && wrData[`SUE_CMD_FAULT_CLEAR];
  assign huntReq = cmdWr && wrData[`SUE_CMD_SEARCH_STATE];

  assign syncMode = isSync(mode);
  assign asyncMode = !syncMode;
  assign extMode = mode[`SUE_MODE_EXT_SYNC];
  assign dblSync = !mode[`SUE_MODE_SINGLE];
  assign parEn = mode[`SUE_MODE_PAR_EN];
  assign parEven = mode[`SUE_MODE_PAR_EVEN];
  assign charLen = `SUE_MIN_LEN +
                   {2'h0, mode[`SUE_MODE_LEN_HI:`SUE_MODE_LEN_LO]};
  assign operational = ctlState == sue_pkg::CTL_CMD;
  assign txPermit = command[`SUE_CMD_TX_PERMIT];
  assign rxPermit = command[`SUE_CMD_RX_PERMIT];

  // Control word sequencing
  always_ff @(posedge clock) begin
    if (rst) begin
      ctlState <= sue_pkg::CTL_MODE;
      mode <= `SUE_RST_BYTE;
      sync1 <= `SUE_RST_BYTE;
      sync2 <= `SUE_RST_BYTE;
      command <= `SUE_RST_BYTE;
    end else if (ctlWr) begin
      case (ctlState)
        sue_pkg::CTL_MODE: begin
          mode <= wrData;
          ctlState <= isSync(wrData) ? sue_pkg::CTL_SYNC1 : sue_pkg::CTL_CMD;
        end
        sue_pkg::CTL_SYNC1: begin
          sync1 <= wrData;
          ctlState <= dblSync ? sue_pkg::CTL_SYNC2 : sue_pkg::CTL_CMD;
        end
        sue_pkg::CTL_SYNC2: begin
          sync2 <= wrData;
          ctlState <= sue_pkg::CTL_CMD;
        end
        sue_pkg::CTL_CMD: begin
          command <= softRst ? `SUE_RST_BYTE : wrData;
          if (softRst) begin
            ctlState <= sue_pkg::CTL_MODE;
          end
        end
        default: ctlState <= sue_pkg::CTL_MODE;
      endcase
    end
  end

  // Transmit character and frame assembly
  always_comb begin
    txChar = bufFull ? txBuf : ((dblSync && fillSel) ? sync2 : sync1);
    dataMasked = txChar & lenMask(charLen);
    parBit = parEn && (^dataMasked ^ !parEven);
    txFrame = {3'h0, dataMasked} | ({10'h000, parBit} << charLen);
    txLen = charLen + {3'h0, parEn};
    if (asyncMode) begin
      txFrame = {txFrame[9:0], 1'b0} | (11'h001 << (txLen + 4'h1));
      txLen = txLen + 4'h2;
    end
  end

  // Sync fill only once a host character has gone out
  assign loadValid = operational && txPermit && ctsOk &&
                     (bufFull || (syncMode && txStarted));

  sue_tx u_tx (
    .clock(clock),
    .rst(rst || softRst),
    .shiftNow(txFall),
    .loadValid(loadValid),
    .loadFrame(txFrame),
    .loadLen(txLen),
    .taking(taking),
    .lastBit(lastBit),
    .txd(txd)
  );

  always_ff @(posedge clock) begin
    if (rst || softRst) begin
      txBuf <= `SUE_RST_BYTE;
      bufFull <= 1'b0;
      txStarted <= 1'b0;
      fillSel <= 1'b0;
    end else begin
      if (dataWr) begin
        txBuf <= wrData;
      end
      // A write in the take cycle refills the buffer
      if (dataWr) begin
        bufFull <= 1'b1;
      end else if (taking && bufFull) begin
        bufFull <= 1'b0;
      end
      if (taking && bufFull && syncMode) begin
        txStarted <= 1'b1;
      end
      if (taking) begin
        fillSel <= bufFull ? 1'b0 : (dblSync && !fillSel);
      end
    end
  end

  // Rising bit-clock edge is the middle of the outgoing bit
  assign idleSet = txRise && lastBit && !bufFull &&
                   (asyncMode || txStarted);

  always_ff @(posedge clock) begin
    if (rst || softRst) begin
      transmitterIdleFlag <= 1'b0;
    end else if (idleSet) begin
      transmitterIdleFlag <= 1'b1;
    end else if (dataWr) begin
      transmitterIdleFlag <= 1'b0;
    end
  end

  sue_rx u_rx (
    .clock(clock),
    .rst(rst),
    .restart(softRst || modeWr),
    .bitNow(rxRise),
    .bitIn(pinSync[3]),
    .enable(operational && rxPermit),
    .huntReq(huntReq),
    .extSync(extEdge && extMode && syncMode),
    .extMode(extMode),
    .asyncMode(asyncMode),
    .dblSync(dblSync),
    .len(charLen),
    .parEn(parEn),
    .parEven(parEven),
    .sync1(sync1),
    .sync2(sync2),
    .charDone(rxCharDone),
    .rxData(rxData),
    .parityBad(rxParityBad),
    .frameBad(rxFrameBad),
    .syncHit(syncHit)
  );

  // Sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst || softRst) begin
      rxReady <= 1'b0;
    end else if (rxCharDone) begin
      rxReady <= 1'b1;
    end else if (dataRd) begin
      rxReady <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || softRst) begin
      overrun <= 1'b0;
    end else if (rxCharDone && rxReady && !dataRd) begin
      overrun <= 1'b1;
    end else if (faultClr) begin
      overrun <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || softRst) begin
      parityFault <= 1'b0;
    end else if (rxCharDone && rxParityBad) begin
      parityFault <= 1'b1;
    end else if (faultClr) begin
      parityFault <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || softRst) begin
      frameFault <= 1'b0;
    end else if (rxCharDone && rxFrameBad && asyncMode) begin
      frameFault <= 1'b1;
    end else if (faultClr) begin
      frameFault <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || softRst) begin
      syncFound <= 1'b0;
    end else if (syncHit || (extEdge && extMode && syncMode)) begin
      syncFound <= 1'b1;
    end else if (stRd) begin
      syncFound <= 1'b0;
    end
  end

  // Live flags feed the status byte with no extra delay
  always_comb begin
    status = `SUE_RST_BYTE;
    status[`SUE_ST_SLOT_FREE] = !bufFull;
    status[`SUE_ST_RX_READY] = rxReady;
    status[`SUE_ST_TX_IDLE] = transmitterIdleFlag;
    status[`SUE_ST_PARITY] = parityFault;
    status[`SUE_ST_OVERRUN] = overrun;
    status[`SUE_ST_FRAME] = frameFault;
    status[`SUE_ST_SYNC_FOUND] = syncFound;
    status[`SUE_ST_DSR] = !pinSync[1];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdData <= `SUE_RST_BYTE;
    end else if (stRd) begin
      rdData <= status;
    end else if (dataRd) begin
      rdData <= rxData;
    end else begin
      rdData <= `SUE_RST_BYTE;
    end
  end

  assign transmitSlotFree = !bufFull && ctsOk && txPermit;
  assign rxReadyPin = rxReady;
  assign rtsN = !command[`SUE_CMD_RTS];
  assign dtrN = !command[`SUE_CMD_DTR];
  assign syncFoundOut = syncFound;
  assign syncFoundOe = operational && syncMode && !extMode;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_upper_zero;
    rxCharDone |-> (rxData & ~lenMask(charLen)) == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("Unused receive bits not zero");

  property p_start_gate;
    taking |-> txPermit && ctsOk && operational;
  endproperty
  a_start_gate: assert property (p_start_gate)
    else $error("Transmit started without permit or CTS");

  property p_shift_on_fall;
    $changed(txd) |-> $past(txFall) || $past(softRst);
  endproperty
  a_shift_on_fall: assert property (p_shift_on_fall)
    else $error("Serial output changed off a falling clock edge");

  property p_fill;
    txFall && lastBit && syncMode && txStarted && txPermit && ctsOk &&
      operational |-> taking;
  endproperty
  a_fill: assert property (p_fill)
    else $error("Line not filled after buffer ran dry");

  property p_idle_clear;
    dataWr && !idleSet |=> !transmitterIdleFlag;
  endproperty
  a_idle_clear: assert property (p_idle_clear)
    else $error("Idle flag not cleared by host character");

  property p_idle_rise;
    $rose(transmitterIdleFlag) |-> $past(txRise && lastBit && !bufFull);
  endproperty
  a_idle_rise: assert property (p_idle_rise)
    else $error("Idle flag rose away from mid last bit");

  property p_sync_found;
    syncHit |=> syncFound ##1 (syncFound || $past(stRd));
  endproperty
  a_sync_found: assert property (p_sync_found)
    else $error("Sync found not raised on match");

  property p_no_frame_sync;
    $rose(frameFault) |-> $past(asyncMode);
  endproperty
  a_no_frame_sync: assert property (p_no_frame_sync)
    else $error("Frame fault raised in sync mode");

  property p_command_load;
    cmdWr && !softRst |=> command == $past(wrData);
  endproperty
  a_command_load: assert property (p_command_load)
    else $error("Control write did not load command");

  property p_reinit;
    softRst |=> ctlState == sue_pkg::CTL_MODE && command == 8'h00;
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("Soft reinit did not return to mode word");

  property p_status_read;
    stRd |=> rdData == $past(status) ##1 rdData == 8'h00 || $past(rdStb);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Status read returned wrong byte");

  property p_parity;
    rxCharDone && rxParityBad |=> parityFault [*2] or
      (parityFault ##1 $past(faultClr));
  endproperty
  a_parity: assert property (p_parity)
    else $error("Parity fault not held");

  property p_overrun;
    rxCharDone && rxReady && !dataRd |=> overrun && rxReady;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("Overrun not flagged");

  property p_slot_pin;
    transmitSlotFree |-> status[`SUE_ST_SLOT_FREE] && !pinSync[2];
  endproperty
  a_slot_pin: assert property (p_slot_pin)
    else $error("Slot free pin disagrees with status");

  c_sync_hit: cover property (syncHit ##[1:8] stRd);
  c_fill_sent: cover property (taking && !bufFull);
  c_overrun: cover property ($rose(overrun));
  c_frame: cover property ($rose(frameFault));
endmodule // sue_engine

// ===== sue_line_model.sv
// Modem line model: shared bit clock, serial source and txd capture
`timescale 1ns/100ps
module sue_line_model (
  input wire logic run,
  input wire logic txd,
  output logic bitClock,
  output logic rxd,
  output logic [31:0] heard
);
  logic q[$];
  // Clock parks high whenever the line is stopped
  initial begin
    bitClock = 1'h1;
    rxd = 1'h1;
    heard = 32'h0000_0000;
    forever begin
      #16;
      if (run || !bitClock) bitClock = ~bitClock;
    end
  end
  // New bits go out on the fall, a half period before the rise
  always @(negedge bitClock) rxd <= (q.size() > 0) ? q.pop_front() : 1'h1;
  // Sampled just before the device moves to the next bit
  always @(negedge bitClock) heard <= {txd, heard[31:1]};
  task automatic send(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) q.push_back(v[i]);
  endtask
endmodule // sue_line_model

// ===== sue_engine_test.sv
// Self-checking bench for the synchronous serial engine
`timescale 1ns/100ps
module sue_engine_test;
  logic clock, rst, cdSel, wrStb, rdStb, ctsN, dsrN, syncFoundIn, run;
  logic [7:0] wrData, rdData, st;
  logic bitClock, rxd, txd, rtsN, dtrN, slotFree, rxReady, txIdle;
  logic sfOut, sfOe;
  logic [31:0] heard;
  int error_cnt = 0;
  int total_checks = 0;
  sue_engine uut (.clock(clock), .rst(rst), .cdSel(cdSel),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .transmitBitClock(bitClock), .receiveBitClock(bitClock),
    .rxdPin(rxd), .ctsN(ctsN), .dsrN(dsrN), .syncFoundIn(syncFoundIn),
    .txd(txd), .rtsN(rtsN), .dtrN(dtrN), .transmitSlotFree(slotFree),
    .rxReadyPin(rxReady), .transmitterIdleFlag(txIdle),
    .syncFoundOut(sfOut), .syncFoundOe(sfOe));
  sue_line_model line (.run(run), .txd(txd), .bitClock(bitClock),
    .rxd(rxd), .heard(heard));
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  task automatic end_sim();
    $display("Checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    error_cnt++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    total_checks++;
    if (got !== exp) fail(m);
  endtask
  task automatic wr(input logic cd, input logic [7:0] d);
    @(posedge clock);
    cdSel <= cd;
    wrData <= d;
    wrStb <= 1'h1;
    @(posedge clock);
    wrStb <= 1'h0;
    @(negedge clock);
  endtask
  task automatic rd(input logic cd, output logic [7:0] v);
    @(posedge clock);
    cdSel <= cd;
    rdStb <= 1'h1;
    @(posedge clock);
    rdStb <= 1'h0;
    @(negedge clock);
    v = rdData;
  endtask
  // Wait for the line to empty, then let the last character land
  task automatic drain();
    int n;
    for (n = 0; n < 2000 && line.q.size() > 0; n++) @(posedge clock);
    if (n == 2000) begin
      fail("rx timeout");
      end_sim();
    end
    repeat (2) @(negedge bitClock);
    repeat (16) @(posedge clock);
  endtask
  task automatic seek(input logic [23:0] p);
    int n;
    bit hit;
    hit = 1'h0;
    for (n = 0; n < 200 && !hit; n++) begin
      @(posedge bitClock);
      for (int k = 0; k <= 8; k++) if (heard[k +: 24] === p) hit = 1'h1;
    end
    total_checks++;
    if (!hit) begin
      fail("tx stream");
      end_sim();
    end
  endtask
  initial begin
    rst = 1'h1;
    cdSel = 1'h0;
    wrStb = 1'h0;
    rdStb = 1'h0;
    wrData = 8'h00;
    ctsN = 1'h1;
    dsrN = 1'h0;
    syncFoundIn = 1'h0;
    run = 1'h0;
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    @(negedge clock);
    chk({7'h00, txd}, 8'h01, "txd idle");
    chk({6'h00, rtsN, dtrN}, 8'h03, "modem idle");
    wr(1'h1, 8'h0C);
    wr(1'h1, 8'h96);
    wr(1'h1, 8'h69);
    wr(1'h1, 8'hA7);
    run <= 1'h1;
    chk({6'h00, rtsN, dtrN}, 8'h00, "modem on");
    chk({6'h00, slotFree, sfOe}, 8'h01, "pin gated");
    rd(1'h1, st);
    chk(st & 8'h85, 8'h81, "status idle");
    wr(1'h0, 8'h3C);
    repeat (80) @(posedge clock);
    chk({7'h00, txd}, 8'h01, "held mark");
    rd(1'h1, st);
    chk(st & 8'h01, 8'h00, "buffer full");
    ctsN <= 1'h0;
    seek(24'h69_963C);
    chk({7'h00, txIdle}, 8'h01, "idle flag");
    // Write away from the mid-bit set point, where set would win
    @(negedge bitClock);
    wr(1'h0, 8'hE7);
    repeat (4) @(posedge clock);
    chk({7'h00, txIdle}, 8'h00, "idle cleared");
    line.send(16'h6996, 16);
    line.send(16'hC35A, 16);
    drain();
    chk({6'h00, sfOut, rxReady}, 8'h03, "sync and ready");
    rd(1'h1, st);
    chk(st & 8'hFA, 8'hD2, "rx status");
    chk({7'h00, sfOut}, 8'h00, "sync cleared");
    rd(1'h0, st);
    chk(st, 8'hC3, "overwrite");
    wr(1'h1, 8'h37);
    rd(1'h1, st);
    chk(st & 8'h12, 8'h00, "fault clear");
    wr(1'h1, 8'h40);
    wr(1'h1, 8'hF0);
    wr(1'h1, 8'h20);
    chk({7'h00, rtsN}, 8'h01, "sync char stored");
    wr(1'h1, 8'h04);
    chk({6'h00, sfOe, rtsN}, 8'h01, "ext sync pin");
    @(posedge bitClock);
    syncFoundIn <= 1'h1;
    line.send(16'h0013, 6);
    repeat (2) @(posedge bitClock);
    syncFoundIn <= 1'h0;
    drain();
    rd(1'h0, st);
    chk(st, 8'h13, "short char");
    rd(1'h1, st);
    chk(st & 8'h28, 8'h08, "parity no frame");
    wr(1'h1, 8'h04);
    rd(1'h1, st);
    chk(st & 8'h08, 8'h08, "parity held");
    wr(1'h1, 8'h14);
    rd(1'h1, st);
    chk(st & 8'h08, 8'h00, "parity cleared");
    // Async frame with a low stop bit
    wr(1'h1, 8'h40);
    wr(1'h1, 8'h0D);
    wr(1'h1, 8'h04);
    // Let the receiver reach line idle before the start bit
    repeat (2) @(posedge bitClock);
    line.send(16'h014A, 10);
    drain();
    rd(1'h0, st);
    chk(st, 8'hA5, "async char");
    rd(1'h1, st);
    chk(st & 8'h20, 8'h20, "frame fault");
    wr(1'h1, 8'h14);
    rd(1'h1, st);
    chk(st & 8'h20, 8'h00, "frame cleared");
    end_sim();
  end
  initial begin
    #200000;
    fail("watchdog");
    end_sim();
  end
endmodule // sue_engine_test
